// File: ppo_pkg.sv
// ppo_pkg.sv: shared constants and types for the parallel pixel output block
// assumes: ppo_top and ppo_rx_model refer to it by scoped name, ppo_buf does not use it, nothing imports it
//
// Functional notes
// - pixel_clock_out is an inverted, slightly delayed copy of master_clock_in, one pixel a period.
// - pixel data changes with the falling edge of pixel_clock_out, so the receiver samples on its rising edge.
// - line_active and frame_active change on the same master clock rising edge as the pixel data.
// - line_active rises with the first valid pixel of a line and falls on the edge that ends its last pixel.
// - frame_active rises exactly 143 pixel clock periods before the first line_active rise of a frame.
// - frame_active falls exactly 23 pixel clock periods after the last line_active fall of a frame.
package ppo_pkg;

	// ------------------------------------------------------------
	// widths and timing counts
	// ------------------------------------------------------------
	localparam int          PIX_W    = 10;    // pixel data bus width
	localparam int          CNT_W    = 16;    // width of every frame timing counter
	localparam logic [15:0] FRAME_LEAD  = 16'h008f; // 143 pixel clocks frame_active before first line
	localparam logic [15:0] FRAME_TRAIL = 16'h0017; // 23 pixel clocks frame_active after last line

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [9:0]  DATA_RST = 10'h000;
	localparam logic [1:0]  FILL_RST = 2'h0;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	// frame sequencer states, gray coded along idle-pre-line-gap; line-post and post-idle change two bits
	typedef enum logic [2:0] {
		PPO_IDLE = 3'b000,
		PPO_PRE  = 3'b001,
		PPO_LINE = 3'b011,
		PPO_GAP  = 3'b010,
		PPO_POST = 3'b110
	} ppo_state_t;

	// video bus driven towards the receiver
	typedef struct packed {
		logic             frame_active;
		logic             line_active;
		logic [9:0]       data;
	} ppo_video_t;

endpackage : ppo_pkg

// File: ppo_buf.sv
// ppo_buf.sv: two-entry pixel buffer with valid/ready on both sides
// assumes: single clock domain, source and sink on i_clock
`timescale 1ns/1ps
module ppo_buf #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	// filling side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// draining side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]      fill_q, fill_d;
	logic             push, pop;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// ready comes from the fill count register, so a full buffer stalls the source
	always_comb
	begin
		push   = i_in_valid && (fill_q != (AW+1)'(DEPTH));
		pop    = i_out_ready && (fill_q != '0);
		mem_d  = mem_q;
		wr_d   = wr_q;
		rd_d   = rd_q;
		if (push)
		begin
			mem_d[wr_q] = i_in_data;
			wr_d        = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
		end
		if (pop)
			rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
		fill_d = fill_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
			wr_q   <= '0;
			rd_q   <= '0;
			fill_q <= '0;
		end
		else
		begin
			mem_q  <= mem_d;
			wr_q   <= wr_d;
			rd_q   <= rd_d;
			fill_q <= fill_d;
		end
	end

	assign o_in_ready  = (fill_q != (AW+1)'(DEPTH));
	assign o_out_valid = (fill_q != '0);
	assign o_out_data  = mem_q[rd_q];

endmodule : ppo_buf

// File: ppo_top.sv
// ppo_top.sv: parallel pixel output timing, sensor side
// assumes: master_clock_in is a free-running pin clock well below i_clock / 2,
// pixels arrive from the sensor core as a valid/ready stream on i_clock
`timescale 1ns/1ps
module ppo_top #(
	parameter int LINE_PIXELS = 752,
	parameter int FRAME_LINES = 480,
	parameter int LINE_BLANK  = 94,
	parameter int FRAME_BLANK = 40
) (
	// clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_rst,
	// master clock pin
	input  wire logic               i_master_clock_in,
	// pixel stream from the sensor core
	input  wire logic               i_pix_valid,
	input  wire logic [9:0]         i_pix_data,
	output logic                    o_pix_ready,
	// parallel video pins
	output logic                    o_pixel_clock_out,
	output ppo_pkg::ppo_video_t     o_video,
	// status
	output logic                    o_underrun
);

	// ------------------------------------------------------------
	// master clock sampling
	// ------------------------------------------------------------
	logic mclk_s1_q, mclk_s2_q, mclk_s3_q;
	logic mrise;

	// two flops before use; edge found from the second and third only
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			mclk_s1_q <= 1'b0;
			mclk_s2_q <= 1'b0;
			mclk_s3_q <= 1'b0;
		end
		else
		begin
			mclk_s1_q <= i_master_clock_in;
			mclk_s2_q <= mclk_s1_q;
			mclk_s3_q <= mclk_s2_q;
		end
	end

	assign mrise = mclk_s2_q && !mclk_s3_q;

	// ------------------------------------------------------------
	// pixel buffer
	// ------------------------------------------------------------
	logic       bvalid;
	logic [9:0] bdata;
	logic       bpop;
	logic       bready;

	ppo_buf #(
		.WIDTH (ppo_pkg::PIX_W),
		.DEPTH (2)
	) u_buf (
		.i_clock     (i_clock),
		.i_rst       (i_rst),
		.i_in_valid  (i_pix_valid),
		.i_in_data   (i_pix_data),
		.o_in_ready  (bready),
		.o_out_valid (bvalid),
		.o_out_data  (bdata),
		.i_out_ready (bpop)
	);

	// ------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------
	localparam int CW = ppo_pkg::CNT_W;

	ppo_pkg::ppo_state_t state_q, state_d;
	logic [CW-1:0]       cnt_q, cnt_d;     // countdown within a phase
	logic [CW-1:0]       line_q, line_d;   // lines still to send after this one
	ppo_pkg::ppo_video_t vid_q, vid_d;
	logic                pclk_q, pclk_d;
	logic                urun_q, urun_d;
	logic                rdy_q, rdy_d;

	// all video bus changes wait for a master rising edge so they move together
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		line_d  = line_q;
		vid_d   = vid_q;
		urun_d  = 1'b0;
		bpop    = 1'b0;
		pclk_d  = !mclk_s2_q;
		if (mrise)
		begin
			unique case (state_q)
				ppo_pkg::PPO_IDLE:
				begin
					if (bvalid)
					begin
						vid_d.frame_active = 1'b1;
						cnt_d   = ppo_pkg::FRAME_LEAD - 16'h0001;
						line_d  = CW'(FRAME_LINES - 1);
						state_d = ppo_pkg::PPO_PRE;
					end
				end
				ppo_pkg::PPO_PRE, ppo_pkg::PPO_GAP:
				begin
					if (cnt_q == '0)
					begin
						// first pixel and line_active on one edge
						vid_d.line_active = 1'b1;
						vid_d.data        = bvalid ? bdata : ppo_pkg::DATA_RST;
						bpop              = bvalid;
						urun_d            = !bvalid;
						cnt_d             = CW'(LINE_PIXELS - 1);
						state_d           = ppo_pkg::PPO_LINE;
					end
					else
						cnt_d = cnt_q - 16'h0001;
				end
				ppo_pkg::PPO_LINE:
				begin
					if (cnt_q == '0)
					begin
						vid_d.line_active = 1'b0;
						vid_d.data        = ppo_pkg::DATA_RST;
						if (line_q == '0)
						begin
							cnt_d   = ppo_pkg::FRAME_TRAIL - 16'h0001;
							state_d = ppo_pkg::PPO_POST;
						end
						else
						begin
							line_d  = line_q - 16'h0001;
							cnt_d   = CW'(LINE_BLANK - 1);
							state_d = ppo_pkg::PPO_GAP;
						end
					end
					else
					begin
						// a missing pixel goes out as zero; timing never slips
						vid_d.data = bvalid ? bdata : ppo_pkg::DATA_RST;
						bpop       = bvalid;
						urun_d     = !bvalid;
						cnt_d      = cnt_q - 16'h0001;
					end
				end
				ppo_pkg::PPO_POST:
				begin
					if (cnt_q == '0)
					begin
						// frame ends only after line_active is already low
						vid_d.frame_active = 1'b0;
						cnt_d              = CW'(FRAME_BLANK - 1);
						state_d            = ppo_pkg::PPO_IDLE;
					end
					else
						cnt_d = cnt_q - 16'h0001;
				end
				default:
					state_d = ppo_pkg::PPO_IDLE;
			endcase
		end
		if (state_q == ppo_pkg::PPO_IDLE && mrise && cnt_q != '0)
		begin
			// vertical blanking before the next frame may open
			cnt_d              = cnt_q - 16'h0001;
			vid_d.frame_active = 1'b0;
			state_d            = ppo_pkg::PPO_IDLE;
		end
		// ready is registered one cycle ahead: it drops in the cycle the buffer
		// becomes full, so a source that sees it high is always taken
		rdy_d = !((!bready && !bpop) || (bvalid && bready && i_pix_valid && !bpop));
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q <= ppo_pkg::PPO_IDLE;
			cnt_q   <= '0;
			line_q  <= '0;
			vid_q   <= '0;
			pclk_q  <= 1'b1;
			urun_q  <= 1'b0;
			rdy_q   <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			line_q  <= line_d;
			vid_q   <= vid_d;
			pclk_q  <= pclk_d;
			urun_q  <= urun_d;
			rdy_q   <= rdy_d;
		end
	end

	// data and pixel clock fall leave in the same i_clock cycle
	assign o_pixel_clock_out = pclk_q;
	assign o_video           = vid_q;
	assign o_underrun        = urun_q;
	// predicted buffer space, so the pin comes straight from a flop with no lag
	assign o_pix_ready       = rdy_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [CW-1:0] frame_age_q, line_gap_q, pix_n_q;
	logic          mrise_q;

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			frame_age_q <= '0;
			line_gap_q  <= '0;
			pix_n_q     <= '0;
			mrise_q     <= 1'b0;
		end
		else
		begin
			mrise_q <= mrise;
			if (!vid_q.frame_active)
				frame_age_q <= '0;
			else if (mrise)
				frame_age_q <= frame_age_q + 16'h0001;
			if (vid_q.line_active)
				line_gap_q <= '0;
			else if (mrise)
				line_gap_q <= line_gap_q + 16'h0001;
			if (mrise && vid_d.line_active)
				pix_n_q <= vid_q.line_active ? pix_n_q + 16'h0001 : 16'h0001;
		end
	end

	a_pclk_inverted: assert property (@(posedge i_clock) disable iff (i_rst)
		o_pixel_clock_out == !$past(mclk_s2_q)) else $error("pixel clock not inverted");

	a_data_on_fall: assert property (@(posedge i_clock) disable iff (i_rst)
		$changed(o_video.data) |-> $fell(o_pixel_clock_out))
		else $error("data moved off the pixel clock fall");

	a_strobes_aligned: assert property (@(posedge i_clock) disable iff (i_rst)
		$changed(o_video) |-> mrise_q) else $error("video bus moved off master edge");

	a_line_length: assert property (@(posedge i_clock) disable iff (i_rst)
		$fell(o_video.line_active) |-> pix_n_q == CW'(LINE_PIXELS))
		else $error("line length wrong");

	a_first_pixel: assert property (@(posedge i_clock) disable iff (i_rst)
		$rose(o_video.line_active) |-> ($past(bpop) || o_underrun))
		else $error("line rose without first pixel");

	a_frame_lead: assert property (@(posedge i_clock) disable iff (i_rst)
		$rose(o_video.line_active) && $past(state_q == ppo_pkg::PPO_PRE)
		|-> frame_age_q == ppo_pkg::FRAME_LEAD) else $error("frame lead not 143");

	a_frame_trail: assert property (@(posedge i_clock) disable iff (i_rst)
		$fell(o_video.frame_active) |-> line_gap_q == ppo_pkg::FRAME_TRAIL)
		else $error("frame trail not 23");

	a_line_in_frame: assert property (@(posedge i_clock) disable iff (i_rst)
		o_video.line_active |-> o_video.frame_active)
		else $error("line active outside frame");

endmodule : ppo_top

// File: ppo_rx_model.sv
// ppo_rx_model.sv: video receiver model on the parallel pixel pins
// assumes: pins come straight from ppo_top, no board delay modelled
`timescale 1ns/1ps
module ppo_rx_model (
	// parallel video pins
	input  wire logic                i_pixel_clock_out,
	input  wire ppo_pkg::ppo_video_t i_video
);
	// ------------------------------------------------------------
	// capture
	// ------------------------------------------------------------
	// one word per pixel clock, read back and cleared by the bench
	ppo_pkg::ppo_video_t samples [$];

	// rising edge sits mid-way between data changes, so no setup race
	always @(posedge i_pixel_clock_out)
	begin
		samples.push_back(i_video);
	end
endmodule : ppo_rx_model

// File: tb_ppo_top.sv
// tb_ppo_top.sv: self-checking bench for the parallel pixel output block
// assumes: ppo_pkg, ppo_buf, ppo_top and ppo_rx_model are compiled first
`timescale 1ns/1ps
module tb_ppo_top;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int       LIMIT = 20000; // several short frames of margin
	logic                i_clock     = 1'b0;
	logic                i_rst       = 1'b1;
	logic                mclk        = 1'b0;
	logic                pix_valid   = 1'b0;
	logic [9:0]          pix_data    = 10'h000;
	logic                pix_ready;
	logic                pclk;
	logic                underrun;
	ppo_pkg::ppo_video_t video;
	ppo_pkg::ppo_video_t prev_video  = '0;
	logic                prev_pclk   = 1'b1;
	int                  n_errors    = 0;
	int                  comparisons = 0;
	int                  cycles      = 0;
	int                  refused     = 0;
	int                  n_under     = 0;
	realtime             t_rise      = 0.0;
	logic [9:0]          exp [8];

	// small counts keep a frame near 1420 cycles
	ppo_top #(.LINE_PIXELS(4), .FRAME_LINES(2), .LINE_BLANK(3), .FRAME_BLANK(2)) i_dut (
		.i_clock(i_clock), .i_rst(i_rst), .i_master_clock_in(mclk),
		.i_pix_valid(pix_valid), .i_pix_data(pix_data), .o_pix_ready(pix_ready),
		.o_pixel_clock_out(pclk), .o_video(video), .o_underrun(underrun));
	ppo_rx_model i_rx (.i_pixel_clock_out(pclk), .i_video(video));

	// ------------------------------------------------------------
	// clocks and monitors
	// ------------------------------------------------------------
	initial
	begin
		forever #10 i_clock = ~i_clock;
	end
	// master clock free-runs, phase offset so its edges never meet i_clock's
	initial
	begin
		#13;
		forever #80 mclk = ~mclk;
	end
	// sampled mid-cycle so the outcome never depends on process order
	always @(negedge i_clock)
	begin
		cycles++;
		if (!i_rst && video !== prev_video)
			chk({prev_pclk, pclk}, 32'h2);
		if (underrun === 1'b1)
			n_under++;
		prev_video = video;
		prev_pclk  = pclk;
		// the limit check stands last so nothing runs after the run ends
		if (cycles == LIMIT)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	// one pixel clock per master period
	always @(posedge pclk)
	begin
		if (!i_rst)
		begin
			if (t_rise > 0.0)
				chk(32'(int'($realtime - t_rise)), 32'd160);
			t_rise = $realtime;
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		comparisons++;
		if (got !== want)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk

	task automatic tally_and_finish();
		if (n_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// word held until a mid-cycle look shows ready, then taken at the next edge
	task automatic send_pix(input logic [9:0] v);
		pix_data <= v;
		@(negedge i_clock);
		while (pix_ready !== 1'b1)
		begin
			refused++;
			@(negedge i_clock);
		end
		@(posedge i_clock);
	endtask : send_pix

	task automatic wait_frame();
		while (video.frame_active !== 1'b1)
			@(negedge i_clock);
		while (video.frame_active === 1'b1)
			@(negedge i_clock);
		repeat (40) @(negedge i_clock);
		@(posedge i_clock);
	endtask : wait_frame

	// walks the receiver's words: strobe placement, line pixels, data
	task automatic check_frame();
		int                  f0;
		int                  l0;
		int                  lz;
		int                  fz;
		int                  n;
		ppo_pkg::ppo_video_t s;
		f0 = -1;
		l0 = -1;
		lz = -1;
		fz = -1;
		n  = 0;
		foreach (i_rx.samples[k])
		begin
			s = i_rx.samples[k];
			if (s.frame_active === 1'b1 && f0 < 0)
				f0 = k;
			if (s.frame_active !== 1'b1 && f0 >= 0 && fz < 0)
				fz = k;
			if (s.line_active === 1'b1)
			begin
				chk(s.frame_active, 32'h1);
				if (l0 < 0)
					l0 = k;
				lz = k;
				if (n < 8)
					chk(s.data, exp[n]);
				n++;
			end
		end
		chk(l0 - f0, 32'd143);
		chk(fz - lz - 1, 32'd23);
		chk(n, 32'd8);
	endtask : check_frame

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		chk({underrun, pix_ready, pclk, video}, 32'h1000);
	endtask : test_reset

	// buffer fills during the 143-period lead and must refuse, losing nothing
	task automatic test_full_frame();
		refused = 0;
		i_rx.samples.delete();
		for (int k = 0; k < 8; k++)
			exp[k] = 10'h3ff ^ 10'(k * 67);
		pix_valid <= 1'b1;
		for (int k = 0; k < 8; k++)
			send_pix(exp[k]);
		pix_valid <= 1'b0;
		chk(refused != 0, 32'h1);
		wait_frame();
		check_frame();
	endtask : test_full_frame

	// one pixel only: the other seven slots send zero and flag underrun
	task automatic test_underrun();
		n_under = 0;
		i_rx.samples.delete();
		exp = '{10'h2a5, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000};
		pix_valid <= 1'b1;
		send_pix(exp[0]);
		pix_valid <= 1'b0;
		wait_frame();
		check_frame();
		chk(n_under, 32'd7);
	endtask : test_underrun

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge i_clock);
		test_reset();
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clock);
		test_full_frame();
		test_underrun();
		tally_and_finish();
	end
endmodule : tb_ppo_top
